// *** hw/dbc_pkg.sv ***
// constants, field layouts and carrier types for the dual buck register bank
package dbc_pkg;

	// ==================== register offsets ====================
	localparam logic [7:0] GLB_SLEW_OFS   = 8'h11;	// global soft slew settings
	localparam logic [7:0] FLT_FLAG_OFS   = 8'h20;	// fault flags, read clears
	localparam logic [7:0] FLT_MASK_OFS   = 8'h21;	// fault mask
	localparam logic [7:0] FLT_STAT_OFS   = 8'h22;	// live fault status
	localparam logic [7:0] CH1_VOUT_OFS   = 8'h23;	// channel 1 voltage code
	localparam logic [7:0] CH1_CFG1_OFS   = 8'h25;	// channel 1 range and ramp
	localparam logic [7:0] CH1_CFG2_OFS   = 8'h26;	// channel 1 spread and pwm
	localparam logic [7:0] CH1_CFG3_OFS   = 8'h27;	// channel 1 discharge, freq, limit
	localparam logic [7:0] CH2_VOUT_OFS   = 8'h33;	// channel 2 voltage code
	localparam logic [7:0] CH2_CFG1_OFS   = 8'h35;	// channel 2 range and ramp
	localparam logic [7:0] CH2_CFG2_OFS   = 8'h36;	// channel 2 spread and pwm

	// ==================== reset values ====================
	localparam logic [7:0] GLB_SLEW_RST   = 8'h04;	// soft-start code four
	localparam logic [7:0] FLT_MASK_RST   = 8'hFF;	// everything masked
	localparam logic [7:0] CH1_VOUT_RST   = 8'h46;	// channel 1 default code
	localparam logic [7:0] CH2_VOUT_RST   = 8'hA0;	// channel 2 default code
	localparam logic [7:0] CFG1_RST       = 8'h04;	// rise slew code four
	localparam logic [7:0] CFG2_RST       = 8'h02;	// falling slew enabled
	localparam logic [7:0] CFG3_RST       = 8'h86;	// 100 ohm on, tracking off, 1 MHz, limit code two

	// ==================== field layouts ====================
	localparam logic [7:0] GLB_WR_MASK    = 8'h3F;	// upper two bits read zero
	localparam logic [7:0] MASK_RSVD      = 8'hCC;	// reserved mask bits read one
	localparam logic [7:0] FLAG_USED      = 8'h33;	// implemented flag and mask bits
	localparam int         POK_BIT0       = 0;	// power-good flag of channel 1
	localparam int         SC_BIT0        = 4;	// short flag of channel 1
	localparam int         RNG_LSB        = 6;	// range field
	localparam int         FALL_LSB       = 3;	// ramp-down / soft-stop field
	localparam int         RISE_LSB       = 0;	// ramp-up / soft-start field
	localparam int         ENV_LSB        = 6;	// spread envelope field
	localparam int         FSREN_BIT      = 1;	// falling slew enable
	localparam int         FPWM_BIT       = 0;	// forced pwm bit
	localparam int         ADIS100_BIT    = 7;	// weak discharge enable
	localparam int         ADIS7_BIT      = 6;	// strong discharge enable
	localparam int         REFRESH_BIT    = 5;	// bootstrap interval select
	localparam int         FTRAK_BIT      = 4;	// frequency tracking
	localparam int         FREQ_LSB       = 2;	// switching rate field
	localparam int         ILIM_LSB       = 0;	// peak current field

	// ==================== voltage decode ====================
	localparam logic [12:0] LOW_BASE_MV   = 13'h012C;	// 300 mV
	localparam logic [12:0] LOW_STEP_MV   = 13'h0005;	// 5 mV
	localparam logic [7:0]  LOW_TOP_CODE  = 8'hB4;	// saturates from here
	localparam logic [12:0] LOW_MAX_MV    = 13'h04B0;	// 1200 mV
	localparam logic [12:0] MID_BASE_MV   = 13'h03E8;	// 1000 mV
	localparam logic [12:0] MID_STEP_MV   = 13'h000A;	// 10 mV
	localparam logic [7:0]  MID_TOP_CODE  = 8'h8C;	// saturates from here
	localparam logic [12:0] MID_MAX_MV    = 13'h0960;	// 2400 mV
	localparam logic [12:0] HIGH_BASE_MV  = 13'h07D0;	// 2000 mV
	localparam logic [12:0] HIGH_STEP_MV  = 13'h0014;	// 20 mV
	localparam logic [7:0]  HIGH_TOP_CODE = 8'hA0;	// saturates from here
	localparam logic [12:0] HIGH_MAX_MV   = 13'h1450;	// 5200 mV

	// ==================== other decodes ====================
	localparam logic [7:0]  REFRESH_SLOW_US = 8'h80;	// 128 us
	localparam logic [7:0]  REFRESH_FAST_US = 8'h0A;	// 10 us
	localparam logic [10:0] FREQ_0_KHZ    = 11'h1F4;	// 0.5 MHz
	localparam logic [10:0] FREQ_1_KHZ    = 11'h3E8;	// 1.0 MHz
	localparam logic [10:0] FREQ_2_KHZ    = 11'h640;	// 1.6 MHz
	localparam logic [12:0] ILIM_0_MA     = 13'h0898;	// 2.2 A
	localparam logic [12:0] ILIM_1_MA     = 13'h0D48;	// 3.4 A
	localparam logic [12:0] ILIM_2_MA     = 13'h0FA0;	// 4.0 A
	localparam logic [12:0] ILIM_3_MA     = 13'h11F8;	// 4.6 A
	localparam logic [4:0]  SPREAD_1_PCT  = 5'h08;	// +-8 %
	localparam logic [4:0]  SPREAD_2_PCT  = 5'h0C;	// +-12 %
	localparam logic [4:0]  SPREAD_3_PCT  = 5'h10;	// +-16 %

	// ==================== timing ====================
	localparam int CLK_HZ          = 10000000;	// system clock rate
	localparam int DISCHARGE_US    = 1000;	// strong discharge hold, 1 ms
	localparam int DISCHARGE_CYC   = (DISCHARGE_US * (CLK_HZ / 1000000));	// hold in cycles
	localparam int SYNC_STAGES     = 2;	// pin synchroniser depth

	// ==================== carriers ====================
	typedef struct packed {
		logic [12:0] voltage_mv;	// decoded target, 0 when range reserved
		logic        range_valid;	// range code is not reserved
		logic [1:0]  voltage_range;	// range code
		logic [2:0]  rise_slew_code;	// ramp-up slew code
		logic [2:0]  fall_slew_code;	// ramp-down slew code
		logic [4:0]  spread_pct;	// spread envelope in percent, 0 off
		logic        forced_pwm;	// bit or pin
		logic        falling_slew_enable;	// sink current during ramp-down
	} dbc_chan_t;

	typedef struct packed {
		logic        strong_discharge_active;	// 7 ohm path on
		logic        weak_discharge_enable;	// 100 ohm path enabled
		logic [7:0]  bootstrap_interval_us;	// refresh interval
		logic        freq_tracking;	// internal tracking on
		logic [10:0] switching_rate_khz;	// 0 when reserved
		logic [12:0] peak_current_ma;	// peak current limit
	} dbc_ch1_aux_t;

endpackage

// *** hw/dbc_regs.sv ***
// register bank and control decode for the two-channel step-down converter
`timescale 1ns/100ps
`default_nettype none

// Function
// [R1] soft-stop slew code picks one of eight
// [R2] fault flags set on fault, read clears
// [R3] mask per flag, resets to all ones
// [R4] short status: below threshold and enabled
// [R5] power-good status: above threshold and enabled
// [R6] range code selects low, mid, high range
// [R7] host keeps range fixed while output enabled
// [R8] rise slew code, resets to code four
// [R9] fall slew code, same ordering as rise
// [R10] spread envelope off, 8, 12, 16 percent
// [R11] forced pwm is bit OR pin
// [R12] software clears strong discharge without falling slew
// [R13] strong discharge holds 1 ms after soft-stop
// [R14] bootstrap refresh 128 us or 10 us
// [R15] switching rate 0.5, 1.0, 1.6 MHz
// [R16] peak current 2.2 to 4.6 A, reset two
// [R17] voltage code linear in range, saturates
// [R18] unmasked set flag raises buck interrupt
module dbc_regs #(
	parameter int DISCHARGE_CYCLES = dbc_pkg::DISCHARGE_CYC	// strong discharge hold in cycles
) (
	input  wire logic                    clk_in,	// 10 MHz system clock
	input  wire logic                    rst_in,	// synchronous reset, active high
	input  wire logic [7:0]              reg_addr_in,	// register address from serial port
	input  wire logic [7:0]              reg_wdata_in,	// write data
	input  wire logic                    reg_wr_in,	// one-cycle write strobe
	input  wire logic                    reg_rd_in,	// one-cycle read strobe
	output logic [7:0]                   reg_rdata_out,	// read data, valid cycle after strobe
	input  wire logic [1:0]              ch_enable_in,	// channel output enabled, async
	input  wire logic [1:0]              short_below_in,	// output below short threshold, async
	input  wire logic [1:0]              power_good_above_in,	// output above power-good threshold, async
	input  wire logic [1:0]              forced_pwm_pin_in,	// dedicated forced pwm pins, async
	input  wire logic                    ch1_soft_stop_done_in,	// channel 1 soft-stop finished, async
	output logic                         buck_irq_out,	// buck interrupt source bit
	output logic [2:0]                   soft_stop_slew_code_out,	// global soft-stop slew code
	output logic [2:0]                   soft_start_slew_code_out,	// global soft-start slew code
	output wire dbc_pkg::dbc_chan_t [1:0] chan_ctrl_out,	// per-channel decoded control, driven per field
	output dbc_pkg::dbc_ch1_aux_t        ch1_aux_out	// channel 1 discharge, rate, limit
);

	// ==================== elaboration checks ====================
	initial begin
		if (DISCHARGE_CYCLES < 1 || DISCHARGE_CYCLES > 16383) begin
			$error("DISCHARGE_CYCLES must lie in 1..16383");
		end
	end

	// ==================== pin synchronisers ====================
	localparam int NPIN = 9;	// pins passing the synchroniser
	logic [NPIN-1:0] pin_raw;	// gathered raw pins
	logic [NPIN-1:0] sync1_reg;	// first stage, read by second only
	logic [NPIN-1:0] sync2_reg;	// second stage, safe to use
	logic [1:0]      en_s;	// synced enables
	logic [1:0]      short_s;	// synced short comparators
	logic [1:0]      pok_s;	// synced power-good comparators
	logic [1:0]      fpwm_s;	// synced forced pwm pins
	logic            stop_done_s;	// synced soft-stop done

	assign pin_raw = {ch1_soft_stop_done_in, forced_pwm_pin_in, power_good_above_in, short_below_in, ch_enable_in};
	assign {stop_done_s, fpwm_s, pok_s, short_s, en_s} = sync2_reg;

	// two flops per pin
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
		end
	end

	// ==================== status and fault events ====================
	logic [1:0] short_state;	// live short status per channel
	logic [1:0] power_good_state;	// live power-good status per channel
	logic [1:0] short_prev_reg;	// last short status
	logic [1:0] pok_prev_reg;	// last power-good status
	logic [1:0] en_prev_reg;	// last enable
	logic [1:0] short_event;	// short detected this cycle
	logic [1:0] pok_event;	// power-good lost while enabled

	assign short_state      = short_s & en_s;	// [R4]
	assign power_good_state = pok_s & en_s;	// [R5]
	assign short_event      = short_state & ~short_prev_reg;
	assign pok_event        = pok_prev_reg & ~pok_s & en_s & en_prev_reg;

	// history of the live status, for edge detection
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			short_prev_reg <= '0;
			pok_prev_reg   <= '0;
			en_prev_reg    <= '0;
		end else begin
			short_prev_reg <= short_state;
			pok_prev_reg   <= power_good_state;
			en_prev_reg    <= en_s;
		end
	end

	// ==================== register file ====================
	logic [7:0] glb_reg, glb_next;	// global soft slew
	logic [7:0] flag_reg, flag_next;	// fault flags
	logic [7:0] mask_reg, mask_next;	// fault mask
	logic [7:0] vout_reg [2], vout_next [2];	// voltage codes
	logic [7:0] cfg1_reg [2], cfg1_next [2];	// range and ramp
	logic [7:0] cfg2_reg [2], cfg2_next [2];	// spread and pwm
	logic [7:0] cfg3_reg, cfg3_next;	// channel 1 discharge, rate, limit
	logic [7:0] rdata_reg, rdata_next;	// registered read data
	logic [7:0] stat_word;	// assembled status
	logic [7:0] flag_set;	// hardware set terms

	assign stat_word = {2'h0, short_state, 2'h0, power_good_state};
	assign flag_set  = {2'h0, short_event, 2'h0, pok_event};

	// next register values from writes, reads and fault events
	always_comb begin
		glb_next   = glb_reg;
		flag_next  = flag_reg;
		mask_next  = mask_reg;
		vout_next  = vout_reg;
		cfg1_next  = cfg1_reg;
		cfg2_next  = cfg2_reg;
		cfg3_next  = cfg3_reg;
		rdata_next = rdata_reg;
		// read mux, unmapped reads return zero
		if (reg_rd_in) begin
			case (reg_addr_in)
				dbc_pkg::GLB_SLEW_OFS: rdata_next = glb_reg;
				dbc_pkg::FLT_FLAG_OFS: rdata_next = flag_reg;
				dbc_pkg::FLT_MASK_OFS: rdata_next = mask_reg;
				dbc_pkg::FLT_STAT_OFS: rdata_next = stat_word;
				dbc_pkg::CH1_VOUT_OFS: rdata_next = vout_reg[0];
				dbc_pkg::CH1_CFG1_OFS: rdata_next = cfg1_reg[0];
				dbc_pkg::CH1_CFG2_OFS: rdata_next = cfg2_reg[0];
				dbc_pkg::CH1_CFG3_OFS: rdata_next = cfg3_reg;
				dbc_pkg::CH2_VOUT_OFS: rdata_next = vout_reg[1];
				dbc_pkg::CH2_CFG1_OFS: rdata_next = cfg1_reg[1];
				dbc_pkg::CH2_CFG2_OFS: rdata_next = cfg2_reg[1];
				default:               rdata_next = 8'h00;
			endcase
			if (reg_addr_in == dbc_pkg::FLT_FLAG_OFS) begin
				flag_next = 8'h00;	// [R2]
			end
		end
		// writes; the flag and status registers ignore them
		if (reg_wr_in) begin
			case (reg_addr_in)
				dbc_pkg::GLB_SLEW_OFS: glb_next     = reg_wdata_in & dbc_pkg::GLB_WR_MASK;	// [R1]
				dbc_pkg::FLT_MASK_OFS: mask_next    = reg_wdata_in | dbc_pkg::MASK_RSVD;	// [R3]
				dbc_pkg::CH1_VOUT_OFS: vout_next[0] = reg_wdata_in;
				dbc_pkg::CH1_CFG1_OFS: cfg1_next[0] = reg_wdata_in;
				dbc_pkg::CH1_CFG2_OFS: cfg2_next[0] = reg_wdata_in;
				dbc_pkg::CH1_CFG3_OFS: cfg3_next    = reg_wdata_in;
				dbc_pkg::CH2_VOUT_OFS: vout_next[1] = reg_wdata_in;
				dbc_pkg::CH2_CFG1_OFS: cfg1_next[1] = reg_wdata_in;
				dbc_pkg::CH2_CFG2_OFS: cfg2_next[1] = reg_wdata_in;
				default: begin
				end
			endcase
		end
		// a fault in the clearing cycle survives the read
		flag_next = flag_next | flag_set;	// [R2]
	end

	// register state
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			glb_reg     <= dbc_pkg::GLB_SLEW_RST;	// [R8]
			flag_reg    <= 8'h00;
			mask_reg    <= dbc_pkg::FLT_MASK_RST;	// [R3]
			vout_reg[0] <= dbc_pkg::CH1_VOUT_RST;
			vout_reg[1] <= dbc_pkg::CH2_VOUT_RST;
			cfg1_reg[0] <= dbc_pkg::CFG1_RST;	// [R8]
			cfg1_reg[1] <= dbc_pkg::CFG1_RST;
			cfg2_reg[0] <= dbc_pkg::CFG2_RST;
			cfg2_reg[1] <= dbc_pkg::CFG2_RST;
			cfg3_reg    <= dbc_pkg::CFG3_RST;	// [R15] [R16]
			rdata_reg   <= 8'h00;
		end else begin
			glb_reg   <= glb_next;
			flag_reg  <= flag_next;
			mask_reg  <= mask_next;
			vout_reg  <= vout_next;
			cfg1_reg  <= cfg1_next;
			cfg2_reg  <= cfg2_next;
			cfg3_reg  <= cfg3_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign buck_irq_out  = |(flag_reg & ~mask_reg & dbc_pkg::FLAG_USED);	// [R18]

	// ==================== strong discharge timer ====================
	logic [13:0] dis_cnt_reg, dis_cnt_next;	// remaining hold cycles
	logic        stop_prev_reg;	// last soft-stop done level
	logic        adis7_en;	// strong discharge allowed

	// software must keep this clear while falling slew is off; not forced here
	assign adis7_en = cfg3_reg[dbc_pkg::ADIS7_BIT];	// [R12]

	// load on soft-stop completion, count down, drop if disabled
	always_comb begin
		dis_cnt_next = dis_cnt_reg;
		if (!adis7_en) begin
			dis_cnt_next = 14'h0000;
		end else if (stop_done_s && !stop_prev_reg) begin
			dis_cnt_next = 14'(DISCHARGE_CYCLES);	// [R13]
		end else if (dis_cnt_reg != 14'h0000) begin
			dis_cnt_next = dis_cnt_reg - 14'h0001;	// [R13]
		end
	end

	// timer state
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			dis_cnt_reg   <= 14'h0000;
			stop_prev_reg <= 1'b0;
		end else begin
			dis_cnt_reg   <= dis_cnt_next;
			stop_prev_reg <= stop_done_s;
		end
	end

	// ==================== decode ====================
	// linear voltage within range, clipped at the range top
	function automatic logic [12:0] volt_mv(input logic [1:0] rng, input logic [7:0] code);
		logic [12:0] c;
		c = {5'h00, code};
		case (rng)
			2'h0:    volt_mv = (code >= dbc_pkg::LOW_TOP_CODE) ? dbc_pkg::LOW_MAX_MV :
				dbc_pkg::LOW_BASE_MV + dbc_pkg::LOW_STEP_MV * c;
			2'h1:    volt_mv = (code >= dbc_pkg::MID_TOP_CODE) ? dbc_pkg::MID_MAX_MV :
				dbc_pkg::MID_BASE_MV + dbc_pkg::MID_STEP_MV * c;
			2'h2:    volt_mv = (code >= dbc_pkg::HIGH_TOP_CODE) ? dbc_pkg::HIGH_MAX_MV :
				dbc_pkg::HIGH_BASE_MV + dbc_pkg::HIGH_STEP_MV * c;
			default: volt_mv = 13'h0000;	// reserved range
		endcase
	endfunction

	assign soft_stop_slew_code_out  = glb_reg[dbc_pkg::FALL_LSB +: 3];	// [R1]
	assign soft_start_slew_code_out = glb_reg[dbc_pkg::RISE_LSB +: 3];

	// per-channel decode
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic [1:0] rng;	// range code
		logic [1:0] env;	// envelope code
		assign rng = cfg1_reg[ch][dbc_pkg::RNG_LSB +: 2];
		assign env = cfg2_reg[ch][dbc_pkg::ENV_LSB +: 2];
		assign chan_ctrl_out[ch].voltage_range  = rng;	// [R6]
		assign chan_ctrl_out[ch].range_valid    = (rng != 2'h3);	// [R6]
		assign chan_ctrl_out[ch].voltage_mv     = volt_mv(rng, vout_reg[ch]);	// [R17]
		assign chan_ctrl_out[ch].rise_slew_code = cfg1_reg[ch][dbc_pkg::RISE_LSB +: 3];	// [R8]
		assign chan_ctrl_out[ch].fall_slew_code = cfg1_reg[ch][dbc_pkg::FALL_LSB +: 3];	// [R9]
		assign chan_ctrl_out[ch].spread_pct     = (env == 2'h1) ? dbc_pkg::SPREAD_1_PCT :
			(env == 2'h2) ? dbc_pkg::SPREAD_2_PCT :
			(env == 2'h3) ? dbc_pkg::SPREAD_3_PCT : 5'h00;	// [R10]
		assign chan_ctrl_out[ch].forced_pwm     = cfg2_reg[ch][dbc_pkg::FPWM_BIT] | fpwm_s[ch];	// [R11]
		assign chan_ctrl_out[ch].falling_slew_enable = cfg2_reg[ch][dbc_pkg::FSREN_BIT];
	end

	// channel 1 auxiliary decode
	always_comb begin
		ch1_aux_out.strong_discharge_active = (dis_cnt_reg != 14'h0000);	// [R13]
		ch1_aux_out.weak_discharge_enable   = cfg3_reg[dbc_pkg::ADIS100_BIT];
		ch1_aux_out.bootstrap_interval_us   = cfg3_reg[dbc_pkg::REFRESH_BIT] ?
			dbc_pkg::REFRESH_FAST_US : dbc_pkg::REFRESH_SLOW_US;	// [R14]
		ch1_aux_out.freq_tracking           = cfg3_reg[dbc_pkg::FTRAK_BIT];
		case (cfg3_reg[dbc_pkg::FREQ_LSB +: 2])
			2'h0:    ch1_aux_out.switching_rate_khz = dbc_pkg::FREQ_0_KHZ;	// [R15]
			2'h1:    ch1_aux_out.switching_rate_khz = dbc_pkg::FREQ_1_KHZ;	// [R15]
			2'h2:    ch1_aux_out.switching_rate_khz = dbc_pkg::FREQ_2_KHZ;	// [R15]
			default: ch1_aux_out.switching_rate_khz = 11'h000;	// reserved
		endcase
		case (cfg3_reg[dbc_pkg::ILIM_LSB +: 2])
			2'h0:    ch1_aux_out.peak_current_ma = dbc_pkg::ILIM_0_MA;	// [R16]
			2'h1:    ch1_aux_out.peak_current_ma = dbc_pkg::ILIM_1_MA;	// [R16]
			2'h2:    ch1_aux_out.peak_current_ma = dbc_pkg::ILIM_2_MA;	// [R16]
			default: ch1_aux_out.peak_current_ma = dbc_pkg::ILIM_3_MA;	// [R16]
		endcase
	end

endmodule

`default_nettype wire

// *** verification/dbc_host.sv ***
// host model: byte strobe register master for the buck bank
`timescale 1ns/100ps
`default_nettype none
module dbc_host (
	input  wire logic       clk_in,	// system clock
	output logic      [7:0] addr_out,	// register address
	output logic      [7:0] wdata_out,	// write data
	output logic            wr_out,	// write strobe
	output logic            rd_out,	// read strobe
	input  wire logic [7:0] rdata_in	// read data
);
	// ==========================
	// bus idle at time zero
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'h0;
		rd_out = 1'h0;
	end
	// one write; released lines show inverted junk, never stale data
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'h1;
		@(posedge clk_in);
		wr_out <= 1'h0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
	// one read; data is taken one edge after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'h1;
		@(posedge clk_in);
		rd_out <= 1'h0;
		addr_out <= ~a;
		@(posedge clk_in);
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

// *** verification/dbc_regs_assertions.sv ***
// port checker for the buck register bank
`timescale 1ns/100ps
`default_nettype none
module dbc_regs_chk #(
	parameter int DISCHARGE_CYCLES = 10000	// discharge hold
) (
	input wire logic                     clk_in,	// clock
	input wire logic                     rst_in,	// reset
	input wire logic [7:0]               reg_addr_in,	// address
	input wire logic [7:0]               reg_wdata_in,	// write data
	input wire logic                     reg_wr_in,	// write strobe
	input wire logic                     reg_rd_in,	// read strobe
	input wire logic [7:0]               reg_rdata_out,	// read data
	input wire logic [1:0]               ch_enable_in,	// enables
	input wire logic [1:0]               forced_pwm_pin_in,	// pwm pins
	input wire logic                     buck_irq_out,	// interrupt
	input wire logic [2:0]               soft_stop_slew_code_out,	// stop code
	input wire dbc_pkg::dbc_chan_t [1:0] chan_ctrl_out,	// decode
	input wire dbc_pkg::dbc_ch1_aux_t    ch1_aux_out	// ch1 extras
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// ==========================
	// run length of strong discharge
	int unsigned dis_cnt_reg, dis_cnt_next;
	always_comb dis_cnt_next = ch1_aux_out.strong_discharge_active ? dis_cnt_reg + 1 : 0;
	always_ff @(posedge clk_in) dis_cnt_reg <= rst_in ? 0 : dis_cnt_next;
	property p_glb_rsvd;
		reg_rd_in && reg_addr_in == 8'h11 |=> reg_rdata_out[7:6] == 2'h0;
	endproperty
	a_glb_rsvd: assert property (p_glb_rsvd) else $error("slew reserved");
	property p_stop;
		reg_wr_in && reg_addr_in == 8'h11 |=> soft_stop_slew_code_out == $past(reg_wdata_in[5:3]);
	endproperty
	a_stop: assert property (p_stop) else $error("stop code");
	property p_mask_rsvd;
		reg_rd_in && reg_addr_in == 8'h21 |=> (reg_rdata_out & 8'hCC) == 8'hCC;
	endproperty
	a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask reserved");
	property p_irq_masked;
		reg_rd_in && !reg_wr_in && reg_addr_in == 8'h21 ##1 reg_rdata_out == 8'hFF |-> !buck_irq_out;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked irq");
	property p_slew;
		reg_wr_in && reg_addr_in == 8'h25 |=> chan_ctrl_out[0].rise_slew_code == $past(reg_wdata_in[2:0])
			&& chan_ctrl_out[0].fall_slew_code == $past(reg_wdata_in[5:3]);
	endproperty
	a_slew: assert property (p_slew) else $error("slew codes");
	property p_rng;
		reg_wr_in && reg_addr_in == 8'h25 && reg_wdata_in[7:6] == 2'h3
			|=> chan_ctrl_out[0].voltage_mv == 13'h0000 && !chan_ctrl_out[0].range_valid;
	endproperty
	a_rng: assert property (p_rng) else $error("reserved range");
	property p_fpwm;
		forced_pwm_pin_in[0] [*4] |-> chan_ctrl_out[0].forced_pwm;
	endproperty
	a_fpwm: assert property (p_fpwm) else $error("pwm pin");
	property p_stat_off;
		(!ch_enable_in[0]) [*4] ##0 (reg_rd_in && reg_addr_in == 8'h22) |=> !reg_rdata_out[4] && !reg_rdata_out[0];
	endproperty
	a_stat_off: assert property (p_stat_off) else $error("status off");
	property p_dis_len;
		!ch1_aux_out.strong_discharge_active && dis_cnt_reg != 0 && !$past(reg_wr_in) |-> dis_cnt_reg == DISCHARGE_CYCLES;
	endproperty
	a_dis_len: assert property (p_dis_len) else $error("discharge length");
	c_dis: cover property ($rose(ch1_aux_out.strong_discharge_active));
	c_irq: cover property ($rose(buck_irq_out));
	c_pwm: cover property ($rose(chan_ctrl_out[0].forced_pwm));
endmodule
bind dbc_regs dbc_regs_chk #(.DISCHARGE_CYCLES(DISCHARGE_CYCLES)) u_chk (.clk_in, .rst_in, .reg_addr_in,
	.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .ch_enable_in, .forced_pwm_pin_in,
	.buck_irq_out, .soft_stop_slew_code_out, .chan_ctrl_out, .ch1_aux_out);
`default_nettype wire

// *** verification/dbc_regs_test.sv ***
// self-checking testbench for the buck register bank
`timescale 1ns/100ps
`default_nettype none
module dbc_regs_test;
	localparam int DIS = 20;	// short discharge hold
	logic                     clk_in, rst_in;	// clock, reset
	logic [7:0]               addr, wdata, rdata, v;	// bus, read value
	logic                     wr, rd, ssd, irq;	// strobes, stop done, irq
	logic [1:0]               en, sc, pg, pin;	// channel side levels
	logic [2:0]               stop;	// soft-stop code
	dbc_pkg::dbc_chan_t [1:0] ch;	// channel decode
	dbc_pkg::dbc_ch1_aux_t    aux;	// ch1 extras
	int                       num_errors, n_tests;	// counters
	dbc_regs #(.DISCHARGE_CYCLES(DIS)) dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .ch_enable_in(en),
		.short_below_in(sc), .power_good_above_in(pg), .forced_pwm_pin_in(pin), .ch1_soft_stop_done_in(ssd),
		.buck_irq_out(irq), .soft_stop_slew_code_out(stop), .soft_start_slew_code_out(),
		.chan_ctrl_out(ch), .ch1_aux_out(aux));
	dbc_host host (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
		.rdata_in(rdata));
	// ==========================
	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, v);
		chk(v, e);
	endtask
	// write, then let decode settle
	task automatic wrw(input logic [7:0] a, input logic [7:0] d);
		host.wr(a, d);
		@(negedge clk_in);
	endtask
	task automatic end_sim;
		$display("errors %0d, checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// reset values, unmapped reads give zero
	task automatic t_reset;
		logic [15:0] t [12];
		t = '{16'h1104, 16'h2000, 16'h21FF, 16'h2200, 16'h2346, 16'h2504,
			16'h2602, 16'h2786, 16'h33A0, 16'h3504, 16'h3602, 16'h2400};
		foreach (t[i])
			rdchk(t[i][15:8], t[i][7:0]);
		chk(ch[0].voltage_mv, 13'h028A);
		chk(ch[1].voltage_mv, 13'h044C);
		chk(irq, 1'h0);
	endtask
	// reserved bits, read-only places, every slew code
	task automatic t_regs;
		logic [2:0] n;
		wrw(8'h11, 8'hFF);
		rdchk(8'h11, 8'h3F);
		wrw(8'h21, 8'h00);
		rdchk(8'h21, 8'hCC);
		wrw(8'h20, 8'hFF);
		rdchk(8'h20, 8'h00);
		for (int c = 0; c < 8; c++) begin
			n = ~c[2:0];
			wrw(8'h11, {2'h0, c[2:0], n});
			chk(stop, c[2:0]);
			wrw(8'h35, {2'h0, n, c[2:0]});
			chk(ch[1].rise_slew_code, c[2:0]);
			chk(ch[1].fall_slew_code, n);
		end
	endtask
	// voltage per range with saturation, spread, rate, limit, refresh
	task automatic t_decode;
		logic [27:0] vt [8];
		logic [12:0] sp [4], fq [4], il [4];
		vt = '{28'h0_00_012C, 28'h0_B4_04B0, 28'h0_FF_04B0, 28'h1_8B_0956,
			28'h1_FF_0960, 28'h2_01_07E4, 28'h2_A0_1450, 28'h3_10_0000};
		sp = '{13'h0000, 13'h0008, 13'h000C, 13'h0010};
		fq = '{13'h01F4, 13'h03E8, 13'h0640, 13'h0000};
		il = '{13'h0898, 13'h0D48, 13'h0FA0, 13'h11F8};
		foreach (vt[i]) begin
			wrw(8'h25, {vt[i][25:24], 6'h04});
			wrw(8'h23, vt[i][23:16]);
			chk(ch[0].voltage_mv, vt[i][12:0]);
			chk(ch[0].range_valid, vt[i][25:24] != 2'h3);
		end
		for (int c = 0; c < 4; c++) begin
			wrw(8'h26, {c[1:0], 6'h02});
			wrw(8'h27, {2'h2, c[0], 1'h0, c[1:0], c[1:0]});
			chk(ch[0].spread_pct, sp[c]);
			chk(aux.switching_rate_khz, fq[c]);
			chk(aux.peak_current_ma, il[c]);
			chk(aux.bootstrap_interval_us, c[0] ? 8'h0A : 8'h80);
		end
	endtask
	// fault flags, clear on read, mask, live status
	task automatic t_fault;
		wrw(8'h21, 8'h00);
		en <= 2'h3;
		pg <= 2'h3;
		repeat (4) @(negedge clk_in);
		rdchk(8'h22, 8'h03);
		rdchk(8'h20, 8'h00);
		@(posedge clk_in);
		sc <= 2'h1;
		repeat (4) @(negedge clk_in);
		chk(irq, 1'h1);
		rdchk(8'h22, 8'h13);
		rdchk(8'h20, 8'h10);
		rdchk(8'h20, 8'h00);
		chk(irq, 1'h0);
		@(posedge clk_in);
		pg <= 2'h2;
		repeat (4) @(negedge clk_in);
		rdchk(8'h20, 8'h01);
		wrw(8'h21, 8'hFF);
		sc <= 2'h3;
		repeat (4) @(negedge clk_in);
		chk(irq, 1'h0);
		rdchk(8'h20, 8'h20);
		@(posedge clk_in);
		en <= 2'h0;
		repeat (4) @(negedge clk_in);
		rdchk(8'h22, 8'h00);
		@(posedge clk_in);
		sc <= 2'h0;
		pg <= 2'h0;
	endtask
	// forced pwm is register bit or pin
	task automatic t_pwm;
		chk(ch[0].forced_pwm, 1'h0);
		@(posedge clk_in);
		pin <= 2'h1;
		repeat (5) @(negedge clk_in);
		chk(ch[0].forced_pwm, 1'h1);
		chk(ch[1].forced_pwm, 1'h0);
		@(posedge clk_in);
		pin <= 2'h0;
		wrw(8'h36, 8'h03);
		repeat (3) @(negedge clk_in);
		chk(ch[0].forced_pwm, 1'h0);
		chk(ch[1].forced_pwm, 1'h1);
	endtask
	// strong discharge holds a fixed time after soft-stop
	task automatic t_dis;
		int n;
		n = 0;
		wrw(8'h27, 8'hC6);
		ssd <= 1'h1;
		for (int k = 0; k < 60; k++) begin
			@(negedge clk_in);
			if (aux.strong_discharge_active === 1'h1)
				n++;
		end
		chk(n[15:0], DIS[15:0]);
		@(posedge clk_in);
		ssd <= 1'h0;
	endtask
	// clock
	initial begin
		clk_in = 1'h0;
		forever #50 clk_in = ~clk_in;
	end
	// hang guard
	initial begin
		repeat (50000) @(posedge clk_in);
		$display("Error at %0t: run did not finish", $time);
		num_errors++;
		end_sim;
	end
	// main sequence
	initial begin
		num_errors = 0;
		n_tests = 0;
		rst_in = 1'h1;
		en = 2'h0;
		sc = 2'h0;
		pg = 2'h0;
		pin = 2'h0;
		ssd = 1'h0;
		repeat (8) @(posedge clk_in);
		rst_in <= 1'h0;
		t_reset;
		t_regs;
		t_decode;
		t_fault;
		t_pwm;
		t_dis;
		end_sim;
	end
endmodule
`default_nettype wire
